// file: serial_rtc_calendar_core.sv
// serial clock/calendar core: two-wire slave, BCD time chain, wave output, user RAM
// assumes clk at 25 MHz, sclIn/sdaIn/oscIn are asynchronous pins, sda pad is open drain
//
// Notes on behaviour
// - halt bit set stops the oscillator; counters keep their values.
// - pointer is six bits; higher addresses alias down.
// - locations 0x08 to 0x3F are plain user storage.
// - bits shown as zero ignore writes and read zero.
// - wave disabled: pin follows the level bit, which resets low.
// - wave enable bit drives the pin with an oscillator-derived clock.
// - rate select: 1 Hz, 4.096 kHz, 8.192 kHz, 32.768 kHz; resets to 11.
// - time advances on the falling edge of the 1 Hz wave.
// - hours bit 6 picks 12-hour format; bit 5 is PM there.
// - weekday counts 1 to 7 and returns to 1.
// - date rolls at month length with leap years, carries to month.
// - month 1 to 12 carries to year; year 00 to 99, multiples of four leap.
// - sda fall with scl high is start, rise is stop; restart alike.
// - bytes of eight bits, any count; pointer advances per byte.
// - transmitter changes sda only while scl is low.
// - acknowledge driven in ninth clock, released at its falling edge.
// - master nack on read: slave releases sda and waits for stop.
// - slave answers only its own address, D0h write, D1h read.
`timescale 1ns/1ns
`include "rtc_defines.svh"

// ==========================================================
// write buffer between the serial slave and the register array
module rtc_write_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire pushGo = inValid && inReady;
  wire popGo = outValid && outReady;

  // extra pointer bit tells full from empty
  assign inReady = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign outValid = (wr_r != rd_r);
  assign outData = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else if (ce) begin
      if (pushGo) begin
        mem[wr_r[AW-1:0]] <= inData;
        wr_r <= wr_r + 1'b1;
      end
      if (popGo) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule : rtc_write_fifo

// ==========================================================
// top of the core
module serial_rtc_calendar_core
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic oscIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic wavePin
);

  // ==========================================================
  // pin synchronisers; third stage only for edge detection
  logic sclM_r, sclS_r, sclP_r;
  logic sdaM_r, sdaS_r, sdaP_r;
  logic oscM_r, oscS_r, oscP_r;

  // 25 MHz sampling gives over 60 samples per scl period at 400 kHz
  always_ff @(posedge clk) begin
    if (rst) begin
      {sclM_r, sclS_r, sclP_r} <= 3'h7;
      {sdaM_r, sdaS_r, sdaP_r} <= 3'h7;
      {oscM_r, oscS_r, oscP_r} <= 3'h0;
    end else if (ce) begin
      {sclM_r, sclS_r, sclP_r} <= {sclIn, sclM_r, sclS_r};
      {sdaM_r, sdaS_r, sdaP_r} <= {sdaIn, sdaM_r, sdaS_r};
      {oscM_r, oscS_r, oscP_r} <= {oscIn, oscM_r, oscS_r};
    end
  end

  wire sclRise = sclS_r && !sclP_r;
  wire sclFall = !sclS_r && sclP_r;
  // data edges while scl stays high are bus conditions
  wire startEv = sclS_r && sclP_r && sdaP_r && !sdaS_r;
  wire stopEv = sclS_r && sclP_r && !sdaP_r && sdaS_r;

  // ==========================================================
  // register array: time/control at 0..7, user RAM above
  logic [7:0] rf [64];
  logic [7:0] snap_r [`TIME_REGS];
  logic [`DIV_WIDTH-1:0] div_r;
  logic oscHeld_r;

  wire haltOsc = rf[`REG_SECONDS][`OSC_HALT_BIT];
  wire [7:0] ctrl = rf[`REG_CONTROL];
  wire oscRise = oscS_r && !oscP_r && !haltOsc;
  // 1 Hz wave is div_r msb; it falls as the divider wraps
  wire secTick = oscRise && (div_r == `DIV_LAST);

  // ==========================================================
  // BCD and write-mask helpers
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcdInc

  function automatic logic [7:0] wrMask(input logic [5:0] a);
    unique case (a)
      `REG_SECONDS: wrMask = `MASK_SECONDS;
      `REG_MINUTES: wrMask = `MASK_MINUTES;
      `REG_HOURS: wrMask = `MASK_HOURS;
      `REG_WEEKDAY: wrMask = `MASK_WEEKDAY;
      `REG_DATE: wrMask = `MASK_DATE;
      `REG_MONTH: wrMask = `MASK_MONTH;
      `REG_YEAR: wrMask = `MASK_YEAR;
      `REG_CONTROL: wrMask = `MASK_CONTROL;
      default: wrMask = `MASK_RAM;
    endcase
  endfunction : wrMask

  // ==========================================================
  // count chain decode; invalid host values give undefined results
  wire [7:0] hrs = rf[`REG_HOURS];
  wire mode12 = hrs[`HOUR_12_BIT];
  wire pm = hrs[`HOUR_PM_BIT];
  wire [7:0] secInc = bcdInc({1'b0, rf[`REG_SECONDS][6:0]});
  wire [7:0] minInc = bcdInc(rf[`REG_MINUTES]);
  wire [7:0] h24Inc = bcdInc({2'b00, hrs[5:0]});
  wire [7:0] h12Inc = bcdInc({3'b000, hrs[4:0]});
  wire [7:0] dateInc = bcdInc(rf[`REG_DATE]);
  wire [7:0] monInc = bcdInc(rf[`REG_MONTH]);
  wire [7:0] yearInc = bcdInc(rf[`REG_YEAR]);
  wire [7:0] yr = rf[`REG_YEAR];
  wire [4:0] mon = rf[`REG_MONTH][4:0];

  wire secWrap = (rf[`REG_SECONDS][6:0] == 7'h59);
  wire minWrap = (rf[`REG_MINUTES][6:0] == 7'h59);
  // 12-hour day ends at 11 PM -> 12 AM
  wire hrWrap = mode12 ? (pm && hrs[4:0] == 5'h11) : (hrs[5:0] == 6'h23);
  // year ends in 0/4/8 with even tens or 2/6 with odd tens
  wire leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                    : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
  wire shortMon = (mon == 5'h04) || (mon == 5'h06) || (mon == 5'h09) || (mon == 5'h11);
  wire [5:0] lastDay = (mon == 5'h02) ? (leap ? 6'h29 : 6'h28) : (shortMon ? 6'h30 : 6'h31);
  wire dateWrap = (rf[`REG_DATE][5:0] == lastDay);
  wire monWrap = (mon == 5'h12);
  wire yearWrap = (yr == 8'h99);

  wire c1 = secTick && secWrap;
  wire c2 = c1 && minWrap;
  wire c3 = c2 && hrWrap;
  wire c4 = c3 && dateWrap;
  wire c5 = c4 && monWrap;

  wire [7:0] hrNxt12 = (hrs[4:0] == 5'h12) ? {2'b01, pm, 5'h01} :
                       (hrs[4:0] == 5'h11) ? {2'b01, !pm, 5'h12} : {2'b01, pm, h12Inc[4:0]};
  wire [7:0] hrNxt24 = hrWrap ? 8'h00 : {2'b00, h24Inc[5:0]};
  wire [7:0] hrNxt = mode12 ? hrNxt12 : hrNxt24;
  wire [7:0] wdayNxt = (rf[`REG_WEEKDAY][2:0] == 3'h7) ? 8'h01 : {5'h00, rf[`REG_WEEKDAY][2:0] + 3'h1};

  // ==========================================================
  // write buffer: host writes queue here, drained into the array
  wr_entry_s pushEntry;
  wr_entry_s popEntry;
  logic pushReq;
  logic fifoReady;
  logic popValid;
  // drain yields to the count chain so both never write in one cycle
  wire drainGo = popValid && !oscRise;

  rtc_write_fifo #(.W(`FIFO_WIDTH), .D(`FIFO_DEPTH)) wrBuf (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .inData(pushEntry),
    .inValid(pushReq),
    .inReady(fifoReady),
    .outData(popEntry),
    .outValid(popValid),
    .outReady(drainGo)
  );

  // timebase divider; halting freezes it but clears nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= '0;
      oscHeld_r <= 1'b0;
    end else if (ce && !haltOsc) begin
      oscHeld_r <= oscS_r;
      if (oscRise) begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // register array: host writes masked, else the count chain ripples
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `TIME_REGS; i++) begin
        rf[i] <= `TIME_RESET;
      end
      rf[`REG_CONTROL] <= `CTRL_RESET;
    end else if (ce) begin
      if (drainGo) begin
        rf[popEntry.addr] <= popEntry.data & wrMask(popEntry.addr);
      end else if (secTick) begin
        rf[`REG_SECONDS] <= {haltOsc, secWrap ? 7'h00 : secInc[6:0]};
        if (c1) rf[`REG_MINUTES] <= minWrap ? 8'h00 : minInc;
        if (c2) rf[`REG_HOURS] <= hrNxt;
        if (c3) rf[`REG_WEEKDAY] <= wdayNxt;
        if (c3) rf[`REG_DATE] <= dateWrap ? 8'h01 : dateInc;
        if (c4) rf[`REG_MONTH] <= monWrap ? 8'h01 : monInc;
        if (c5) rf[`REG_YEAR] <= yearWrap ? 8'h00 : yearInc;
      end
    end
  end

  // ==========================================================
  // wave output: static level, oscillator or divided oscillator
  logic wavePin_r;
  wire [3:0] rateTaps = {oscHeld_r, div_r[1], div_r[2], div_r[`DIV_WIDTH-1]};
  wire waveRate = rateTaps[ctrl[1:0]];
  wire waveNxt = ctrl[`CTRL_WAVE_EN_BIT] ? waveRate : ctrl[`CTRL_LEVEL_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      wavePin_r <= 1'b0;
    end else if (ce) begin
      wavePin_r <= waveNxt;
    end
  end

  // ==========================================================
  // serial slave
  slave_state_e st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [5:0] ptr_r;
  logic rw_r, first_r, ackOk_r, sdaOe_r, sdaOut_r;

  wire byteIn = (bit_r == 4'h8) && sclFall;
  wire addrHit = (sh_r[7:1] == `SLAVE_ADDR);
  wire addrDone = (st_r == SL_ADDR) && byteIn;
  wire rxDone = (st_r == SL_RX) && byteIn;
  // data bytes need a buffer slot; a full buffer is answered with nack
  wire rxAck = first_r || fifoReady;
  assign pushReq = rxDone && !first_r;
  assign pushEntry = '{addr: ptr_r, data: sh_r};
  // time registers come from the snapshot, the rest live
  wire [7:0] rdByte = (ptr_r < 6'(`TIME_REGS)) ? snap_r[ptr_r[2:0]] : rf[ptr_r];
  wire loadTx = sclFall && (((st_r == SL_ACK) && rw_r) || ((st_r == SL_MACK) && ackOk_r));

  // snapshot taken as a read address is acknowledged
  always_ff @(posedge clk) begin
    if (ce && addrDone && addrHit && sh_r[0]) begin
      for (int i = 0; i < `TIME_REGS; i++) begin
        snap_r[i] <= rf[i];
      end
    end
  end

  // slave sequencing; sda only moves on scl falls or bus conditions
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= SL_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 6'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ackOk_r <= 1'b0;
      sdaOe_r <= 1'b0;
      sdaOut_r <= 1'b0;
    end else if (ce) begin
      if (startEv) begin
        st_r <= SL_ADDR;
        bit_r <= 4'h0;
        sdaOe_r <= 1'b0;
      end else if (stopEv) begin
        st_r <= SL_IDLE;
        sdaOe_r <= 1'b0;
      end else if (loadTx) begin
        st_r <= SL_TX;
        sh_r <= rdByte;
        sdaOe_r <= !rdByte[7];
        ptr_r <= ptr_r + 6'h01;
        bit_r <= 4'h0;
      end else begin
        unique case (st_r)
          SL_IDLE: begin
          end
          SL_ADDR, SL_RX: begin
            if (sclRise) begin
              sh_r <= {sh_r[6:0], sdaS_r};
              bit_r <= bit_r + 4'h1;
            end else if (addrDone) begin
              st_r <= addrHit ? SL_ACK : SL_IDLE;
              sdaOe_r <= addrHit;
              rw_r <= sh_r[0];
              first_r <= !sh_r[0];
            end else if (rxDone) begin
              st_r <= rxAck ? SL_ACK : SL_IDLE;
              sdaOe_r <= rxAck;
              first_r <= 1'b0;
              ptr_r <= first_r ? sh_r[5:0] : ptr_r + {5'h00, fifoReady};
            end
          end
          SL_ACK: begin
            if (sclFall) begin
              st_r <= SL_RX;
              sdaOe_r <= 1'b0;
              bit_r <= 4'h0;
            end
          end
          SL_TX: begin
            if (sclFall && bit_r == 4'h7) begin
              st_r <= SL_MACK;
              sdaOe_r <= 1'b0;
            end else if (sclFall) begin
              sh_r <= {sh_r[6:0], 1'b0};
              sdaOe_r <= !sh_r[6];
              bit_r <= bit_r + 4'h1;
            end
          end
          SL_MACK: begin
            if (sclRise) begin
              ackOk_r <= !sdaS_r;
            end else if (sclFall) begin
              st_r <= SL_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign sdaOut = sdaOut_r;
  assign sdaOe = sdaOe_r;
  assign wavePin = wavePin_r;

  // ==========================================================
  // checks
  // the host may clear the halt bit at any edge, so only the cycle after a halted one is held still
  chk_halt_freeze: assert property (@(posedge clk) disable iff (rst)
    (ce && haltOsc) |-> !secTick ##1 $stable(div_r))
    else $error("divider moved while oscillator halted");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (rf[`REG_WEEKDAY][7:3] == 5'h00) && (rf[`REG_CONTROL][6:5] == 2'b00) && !rf[`REG_MINUTES][7])
    else $error("reserved bit holds a one");

  chk_wave_static: assert property (@(posedge clk) disable iff (rst)
    (ce && !ctrl[`CTRL_WAVE_EN_BIT]) |=> (wavePin == $past(ctrl[`CTRL_LEVEL_BIT])))
    else $error("wave pin not at static level");

  chk_sec_tick: assert property (@(posedge clk) disable iff (rst)
    (ce && !secTick && !drainGo) |=> $stable(rf[`REG_SECONDS]))
    else $error("seconds moved off the wave falling edge");

  chk_wday_wrap: assert property (@(posedge clk) disable iff (rst)
    (ce && c3 && !drainGo && rf[`REG_WEEKDAY][2:0] == 3'h7) |=> (rf[`REG_WEEKDAY] == 8'h01))
    else $error("weekday did not return to one");

  chk_addr_ack: assert property (@(posedge clk) disable iff (rst)
    (ce && addrDone && !startEv && !stopEv) |=> (sdaOe == $past(addrHit)) && (st_r == SL_ACK) == $past(addrHit))
    else $error("address acknowledge wrong");

  chk_ack_release: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r == SL_ACK && sclFall && !rw_r && !startEv && !stopEv) |=> !sdaOe ##1 (st_r == SL_RX))
    else $error("acknowledge not released at ninth fall");

  chk_nack_idle: assert property (@(posedge clk) disable iff (rst)
    (st_r == SL_IDLE) |-> !sdaOe)
    else $error("slave drives sda while waiting for stop");

  chk_sda_low_scl: assert property (@(posedge clk) disable iff (rst)
    $rose(sdaOe) |-> !$past(sclS_r))
    else $error("sda driven while scl high");

  chk_ptr_load: assert property (@(posedge clk) disable iff (rst)
    (ce && rxDone && first_r && !startEv && !stopEv) |=> (ptr_r == $past(sh_r[5:0])) && !pushReq)
    else $error("pointer not loaded from first byte");

  cov_read_byte: cover property (@(posedge clk) disable iff (rst) ce && loadTx && st_r == SL_MACK);
  cov_write_push: cover property (@(posedge clk) disable iff (rst) ce && pushReq && fifoReady);
  cov_fifo_full: cover property (@(posedge clk) disable iff (rst) ce && rxDone && !rxAck);
  cov_year_wrap: cover property (@(posedge clk) disable iff (rst) ce && c5 && yearWrap);

endmodule : serial_rtc_calendar_core

// file: rtc_defines.svh
// constants for the serial clock/calendar core: map, field masks, reset values
// assumes it is included by bare name from the package and the core
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// ==========================================================
// register map (six-bit internal pointer)
`define REG_SECONDS 6'h00
`define REG_MINUTES 6'h01
`define REG_HOURS 6'h02
`define REG_WEEKDAY 6'h03
`define REG_DATE 6'h04
`define REG_MONTH 6'h05
`define REG_YEAR 6'h06
`define REG_CONTROL 6'h07
`define TIME_REGS 8

// ==========================================================
// writable bits per register, reserved bits read zero
`define MASK_SECONDS 8'hff
`define MASK_MINUTES 8'h7f
`define MASK_HOURS 8'h7f
`define MASK_WEEKDAY 8'h07
`define MASK_DATE 8'h3f
`define MASK_MONTH 8'h1f
`define MASK_YEAR 8'hff
`define MASK_CONTROL 8'h93
`define MASK_RAM 8'hff

// ==========================================================
// field positions and reset values
`define OSC_HALT_BIT 7
`define HOUR_12_BIT 6
`define HOUR_PM_BIT 5
`define CTRL_LEVEL_BIT 7
`define CTRL_WAVE_EN_BIT 4
`define CTRL_RESET 8'h03
`define TIME_RESET 8'h00

// ==========================================================
// serial link and timebase
`define SLAVE_ADDR 7'h68
`define DIV_WIDTH 15
`define DIV_LAST 15'h7fff
`define FIFO_WIDTH 14
`define FIFO_DEPTH 8

`endif

// file: rtc_pkg.sv
// types shared by the clock/calendar core and its write buffer
// assumes rtc_defines.svh is on the include path
`include "rtc_defines.svh"

package rtc_pkg;

  // ==========================================================
  // serial slave states
  typedef enum logic [2:0] {
    SL_IDLE,
    SL_ADDR,
    SL_ACK,
    SL_RX,
    SL_TX,
    SL_MACK
  } slave_state_e;

  // ==========================================================
  // one buffered host write: target pointer and byte
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } wr_entry_s;

endpackage : rtc_pkg

// file: i2c_host_model.sv
// two-wire bus host model: drives scl, pulls sda low, reads the resolved wire
// assumes the bench resolves sda with a pull-up and calls these tasks
`timescale 1ns/1ns

module i2c_host_model (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclDrv,
  output logic sdaPullLow
);
  // ==========================================================
  // bit phases
  // 16 clk a quarter: 64 clk a bit, about 390 kHz, just under the bus limit
  initial begin
    sclDrv = 1'b1;
    sdaPullLow = 1'b0;
  end

  task automatic qtr;
    repeat (16) @(negedge clk);
  endtask : qtr

  // start and restart are the same wave: sda falls while scl is high
  task automatic start;
    sdaPullLow = 1'b0;
    qtr();
    sclDrv = 1'b1;
    qtr();
    sdaPullLow = 1'b1;
    qtr();
    sclDrv = 1'b0;
    qtr();
  endtask : start

  task automatic stop;
    sdaPullLow = 1'b1;
    qtr();
    sclDrv = 1'b1;
    qtr();
    sdaPullLow = 1'b0;
    qtr();
  endtask : stop

  // data moves only while scl is low, sampled in mid-high
  task automatic bitx(input logic b, output logic s);
    sdaPullLow = ~b;
    qtr();
    sclDrv = 1'b1;
    qtr();
    s = sdaWire;
    qtr();
    sclDrv = 1'b0;
    qtr();
  endtask : bitx

  // eight bits msb first, then the ninth clock for acknowledge
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : sendByte

  // withholding the ack on the last byte ends a read
  task automatic recvByte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(~ackIt, s);
  endtask : recvByte
endmodule : i2c_host_model

// file: serial_rtc_calendar_core_tb_top.sv
// self-checking bench for the clock/calendar core over its two-wire slave
// assumes the host model file; sda wire has a pull-up, oscillator made here
`timescale 1ns/1ns

module serial_rtc_calendar_core_tb_top;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] rdPtr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_s;

  logic clk, rst, ce, oscIn, oscRun, sdaOut, sdaOe, wavePin, sclDrv, sdaPullLow, sdaWire;
  logic [7:0] rdData, nRise;
  int nFail, checksDone, cycles;
  row_s rows [9];
  logic [7:0] burst [4];
  logic [7:0] expRise [4];

  // ==========================================================
  // wire, clock, oscillator, instances
  assign sdaWire = ~(sdaOe | sdaPullLow);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // oscillator period of 8 clk keeps each level past the synchroniser
  always begin
    repeat (4) @(negedge clk);
    if (oscRun) oscIn = ~oscIn;
  end

  serial_rtc_calendar_core i_serial_rtc_calendar_core (.clk(clk), .rst(rst), .ce(ce), .sclIn(sclDrv),
    .sdaIn(sdaWire), .oscIn(oscIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .wavePin(wavePin));
  i2c_host_model i_i2c_host_model (.clk(clk), .sdaWire(sdaWire), .sclDrv(sclDrv), .sdaPullLow(sdaPullLow));

  // ==========================================================
  // reporting
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : printVerdict

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // a hang in the bus tasks is cut off well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      nFail++;
      printVerdict();
    end
  end

  // ==========================================================
  // bus transfers
  task automatic sendChk(input logic [7:0] b, input logic expAck);
    logic ack;
    i_i2c_host_model.sendByte(b, ack);
    check("ack", {7'h00, ack}, {7'h00, expAck});
  endtask : sendChk

  task automatic setPtr(input logic [7:0] ptr);
    i_i2c_host_model.start();
    sendChk(8'hd0, 1'b1);
    sendChk(ptr, 1'b1);
  endtask : setPtr

  task automatic regWrite(input logic [7:0] ptr, input logic [7:0] d);
    setPtr(ptr);
    sendChk(d, 1'b1);
    i_i2c_host_model.stop();
  endtask : regWrite

  // pointer write, restart, one byte read with nack
  task automatic regRead(input logic [7:0] ptr, output logic [7:0] d);
    setPtr(ptr);
    i_i2c_host_model.start();
    sendChk(8'hd1, 1'b1);
    i_i2c_host_model.recvByte(1'b0, d);
    check("sda released", {7'h00, sdaOe}, 8'h00);
    i_i2c_host_model.stop();
  endtask : regRead

  // counts wave rises over 512 clk; phase may add or lose one
  task automatic waveCheck(input logic [7:0] e);
    logic prev;
    nRise = 8'h00;
    prev = wavePin;
    repeat (512) begin
      @(negedge clk);
      if (wavePin && !prev) nRise++;
      prev = wavePin;
    end
    check("wave rises near", {7'h00, (nRise + 8'h01 >= e && nRise <= e + 8'h01)}, 8'h01);
  endtask : waveCheck

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    oscIn = 1'b0;
    oscRun = 1'b0;
    nFail = 0;
    checksDone = 0;
    cycles = 0;
    // oscillator idle here, so out-of-range mask probes never reach the count chain; hour format in same byte
    rows = '{'{8'h01, 8'h01, 8'hff, 8'h7f}, '{8'h03, 8'h03, 8'hff, 8'h07}, '{8'h05, 8'h05, 8'hff, 8'h1f},
      '{8'h07, 8'h07, 8'hff, 8'h93}, '{8'h02, 8'h02, 8'h72, 8'h72}, '{8'h08, 8'h08, 8'ha5, 8'ha5},
      '{8'h3f, 8'h3f, 8'h5a, 8'h5a}, '{8'h46, 8'h06, 8'h99, 8'h99}, '{8'h48, 8'h08, 8'h3c, 8'h3c}};
    burst = '{8'h11, 8'h22, 8'h33, 8'h44};
    expRise = '{8'h00, 8'h08, 8'h10, 8'h40};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // table of writes and read-backs: masks, storage, aliasing, hour format
    foreach (rows[i]) begin
      regWrite(rows[i].ptr, rows[i].data);
      regRead(rows[i].rdPtr, rdData);
      check("read back", rdData, rows[i].exp);
    end
    // level out, then a mid-run reset returns pin and control to defaults
    regWrite(8'h07, 8'h80);
    check("level high", {7'h00, wavePin}, 8'h01);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("level after reset", {7'h00, wavePin}, 8'h00);
    check("sda after reset", {6'h00, sdaOut, sdaOe}, 8'h00);
    regRead(8'h07, rdData);
    check("control reset", rdData, 8'h03);
    // burst write across the top of the map wraps to zero
    setPtr(8'h3e);
    foreach (burst[i]) sendChk(burst[i], 1'b1);
    i_i2c_host_model.stop();
    setPtr(8'h3e);
    i_i2c_host_model.start();
    sendChk(8'hd1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      i_i2c_host_model.recvByte(i < 2, rdData);
      check("burst read", rdData, burst[i]);
    end
    i_i2c_host_model.stop();
    // a read with no pointer write carries on from where the last one stopped
    i_i2c_host_model.start();
    sendChk(8'hd1, 1'b1);
    i_i2c_host_model.recvByte(1'b0, rdData);
    i_i2c_host_model.stop();
    check("read continues", rdData, 8'h44);
    // foreign addresses get no acknowledge
    i_i2c_host_model.start();
    sendChk(8'ha0, 1'b0);
    i_i2c_host_model.stop();
    i_i2c_host_model.start();
    sendChk(8'hd3, 1'b0);
    i_i2c_host_model.stop();
    // every rate with the oscillator running
    oscRun = 1'b1;
    for (int r = 0; r < 4; r++) begin
      regWrite(8'h07, 8'h10 | r[7:0]);
      waveCheck(expRise[r]);
    end
    // halt stops the oscillator output but the counters keep their values
    regWrite(8'h00, 8'h80);
    waveCheck(8'h00);
    regRead(8'h00, rdData);
    check("halted seconds kept", rdData, 8'h80);
    printVerdict();
  end
endmodule : serial_rtc_calendar_core_tb_top
